// ==== imfs_defs.svh ====
`ifndef IMFS_DEFS_SVH
`define IMFS_DEFS_SVH

// ****************************************************************
// register addresses (byte addresses on the register bus)
// ****************************************************************
`define IMFS_MISSED_IRQ_FLAGS_ADDR 32'h4000a820
`define IMFS_AUX_BUS_FAULT_CAUSE_ADDR 32'he000ed3c
`define IMFS_EVENT_STATUS_ADDR 32'h4000a880
`define IMFS_EVENT_MASK_ADDR 32'h4000a884

// ****************************************************************
// reset values and implemented-bit masks
// ****************************************************************
`define IMFS_MISSED_IRQ_FLAGS_RESET 32'h0000_0000
`define IMFS_MISSED_IRQ_FLAGS_MASK 32'h0000_fffc
`define IMFS_AUX_BUS_FAULT_CAUSE_RESET 32'h0000_0000
`define IMFS_AUX_BUS_FAULT_CAUSE_MASK 32'h0000_000f
`define IMFS_EVENT_RESET 32'h0000_0000
`define IMFS_EVENT_MASK_BITS 32'h0000_0003

// ****************************************************************
// field positions
// ****************************************************************
`define IMFS_PIN_IRQ_D_LOST_BIT 15
`define IMFS_PIN_IRQ_A_LOST_BIT 12
`define IMFS_CONVERTER_IRQ_LOST_BIT 11
`define IMFS_RADIO_RX_IRQ_LOST_BIT 10
`define IMFS_RADIO_TIMER_IRQ_LOST_BIT 8
`define IMFS_SECURITY_IRQ_LOST_BIT 7
`define IMFS_SLEEP_TIMER_IRQ_LOST_BIT 4
`define IMFS_MANAGEMENT_IRQ_LOST_BIT 2
`define IMFS_BAD_WIDTH_FAULT_BIT 3
`define IMFS_PRIVILEGE_FAULT_BIT 2
`define IMFS_UNMAPPED_ADDRESS_FAULT_BIT 1
`define IMFS_OVERLAP_FAULT_BIT 0
`define IMFS_EV_MISSED_BIT 0
`define IMFS_EV_FAULT_BIT 1

// ****************************************************************
// bus answers
// ****************************************************************
`define IMFS_RESP_OKAY 2'b00
`define IMFS_RESP_SLVERR 2'b10

// ****************************************************************
// memory map of the checked regions
// ****************************************************************
`define IMFS_APB_BASE 32'h4000_0000
`define IMFS_APB_BLOCKS 16
`define IMFS_APB_LAST_OFF {16{12'h0fc}}
`define IMFS_SYS_APB_BASE 32'h4000_0000
`define IMFS_SYS_APB_SIZE 32'h0000_4000
`define IMFS_SYS_AHB_BASE 32'he000_0000
`define IMFS_SYS_AHB_SIZE 32'h0010_0000
`define IMFS_RAM_BASE 32'h2000_0000
`define IMFS_RAM_SIZE 32'h0000_3000
`define IMFS_RAM_WIN 32'h2000_0000
`define IMFS_PROT_RAM_BASE 32'h2000_0000
`define IMFS_PROT_RAM_SIZE 32'h0000_0400
`define IMFS_FLASH_BASE 32'h0000_0000
`define IMFS_FLASH_SIZE 32'h0002_0000
`define IMFS_FLASH_WIN 32'h2000_0000

`endif

// ==== imfs_fault_classify.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "imfs_defs.svh"

// classifies one fabric access into bus fault causes, purely combinational
module imfs_fault_classify import imfs_pkg::*; #(
  parameter logic [31:0] APB_BASE = `IMFS_APB_BASE,
  parameter int APB_BLOCKS = `IMFS_APB_BLOCKS,
  parameter logic [16*12-1:0] APB_LAST_OFF = `IMFS_APB_LAST_OFF,
  parameter logic [31:0] SYS_APB_BASE = `IMFS_SYS_APB_BASE,
  parameter logic [31:0] SYS_APB_SIZE = `IMFS_SYS_APB_SIZE,
  parameter logic [31:0] SYS_AHB_BASE = `IMFS_SYS_AHB_BASE,
  parameter logic [31:0] SYS_AHB_SIZE = `IMFS_SYS_AHB_SIZE,
  parameter logic [31:0] RAM_BASE = `IMFS_RAM_BASE,
  parameter logic [31:0] RAM_SIZE = `IMFS_RAM_SIZE,
  parameter logic [31:0] RAM_WIN = `IMFS_RAM_WIN,
  parameter logic [31:0] PROT_RAM_BASE = `IMFS_PROT_RAM_BASE,
  parameter logic [31:0] PROT_RAM_SIZE = `IMFS_PROT_RAM_SIZE,
  parameter logic [31:0] FLASH_BASE = `IMFS_FLASH_BASE,
  parameter logic [31:0] FLASH_SIZE = `IMFS_FLASH_SIZE,
  parameter logic [31:0] FLASH_WIN = `IMFS_FLASH_WIN
) (
  // observed access
  input wire imfs_access_s acc,
  // causes found
  output imfs_cause_s cause
);

  // ****************************************************************
  // region decode
  // ****************************************************************
  // half-open window test, done in 33 bits so a window at the top does not wrap
  function automatic logic in_win(input logic [31:0] a, input logic [31:0] b,
                                  input logic [31:0] s);
    in_win = ({1'b0, a} >= {1'b0, b}) && ({1'b0, a} < ({1'b0, b} + {1'b0, s}));
  endfunction : in_win

  localparam logic [31:0] APB_SPAN = 32'(APB_BLOCKS) << 12;

  wire logic in_apb = in_win(acc.addr, APB_BASE, APB_SPAN);
  wire logic [3:0] blk_idx = acc.addr[15:12];
  wire logic [11:0] blk_last = APB_LAST_OFF[blk_idx*12 +: 12];
  wire logic in_sys = in_win(acc.addr, SYS_APB_BASE, SYS_APB_SIZE) ||
                      in_win(acc.addr, SYS_AHB_BASE, SYS_AHB_SIZE);
  wire logic in_prot_ram = in_win(acc.addr, PROT_RAM_BASE, PROT_RAM_SIZE);
  // above top of ram or flash but still inside its address window
  wire logic past_ram = in_win(acc.addr, RAM_BASE, RAM_WIN) &&
                        !in_win(acc.addr, RAM_BASE, RAM_SIZE);
  wire logic past_flash = in_win(acc.addr, FLASH_BASE, FLASH_WIN) &&
                          !in_win(acc.addr, FLASH_BASE, FLASH_SIZE);
  wire logic word_misaligned = (acc.size == IMFS_SZ_WORD) && (acc.addr[1:0] != 2'b00);

  // ****************************************************************
  // causes
  // ****************************************************************
  assign cause.bad_width_fault = (in_apb && acc.size != IMFS_SZ_WORD) ||
                                 word_misaligned; // [RULE4]
  assign cause.privilege_fault = acc.write && !acc.priv &&
                                 (in_sys || in_prot_ram); // [RULE5]
  assign cause.unmapped_address_fault = (in_apb && acc.addr[11:0] > blk_last) || // [RULE6]
                                        past_ram || past_flash; // [RULE7]

endmodule : imfs_fault_classify

`default_nettype wire

// ==== imfs_pkg.sv ====
package imfs_pkg;

  // ****************************************************************
  // access width as seen on the monitored fabric
  // ****************************************************************
  typedef enum logic [1:0] {
    IMFS_SZ_BYTE = 2'b00,
    IMFS_SZ_HALF = 2'b01,
    IMFS_SZ_WORD = 2'b10
  } imfs_size_e;

  // one observed fabric access
  typedef struct packed {
    logic [31:0] addr;
    imfs_size_e size;
    logic write;
    logic priv;
  } imfs_access_s;

  // causes found for one access, before the overlap check
  typedef struct packed {
    logic bad_width_fault;
    logic privilege_fault;
    logic unmapped_address_fault;
  } imfs_cause_s;

endpackage : imfs_pkg

// ==== imfs_status_props.sv ====
`timescale 1ns/1ps
`default_nettype none

// **********
// bus handshake and fault cause checks on the top ports
// **********
module imfs_status_props import imfs_pkg::*; (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // fabric side
  input wire logic fab_access_valid,
  input wire imfs_access_s fab_access,
  input wire logic fab_fault
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  // default memory map only, redo for other maps
  logic in_apb;
  logic in_sys_apb;
  logic beyond_mem;
  assign in_apb = fab_access.addr[31:16] == 16'h4000;
  assign in_sys_apb = fab_access.addr[31:14] == 18'h10000;
  assign beyond_mem = (fab_access.addr[31:29] == 3'b001 && fab_access.addr[28:0] >= 29'h3000)
    || (fab_access.addr[31:29] == 3'b000 && fab_access.addr[28:0] >= 29'h20000);

  // handshake steps
  sequence wr_both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence acc_seen;
    fab_access_valid;
  endsequence

  width_fault_a: assert property (acc_seen and
    (fab_access.size != IMFS_SZ_WORD && in_apb) |=> fab_fault)
    else $error("narrow apb access gave no fault");
  misalign_fault_a: assert property (acc_seen and
    (fab_access.size == IMFS_SZ_WORD && fab_access.addr[1:0] != 2'b00) |=> fab_fault)
    else $error("misaligned word gave no fault");
  priv_fault_a: assert property (acc_seen and
    (fab_access.write && !fab_access.priv && in_sys_apb) |=> fab_fault)
    else $error("user write to system apb gave no fault");
  apb_gap_a: assert property (acc_seen and
    (in_apb && fab_access.addr[11:0] > 12'h0fc) |=> fab_fault)
    else $error("access above last apb register gave no fault");
  mem_beyond_a: assert property (acc_seen and beyond_mem |=> fab_fault)
    else $error("access past memory end gave no fault");
  fault_cause_a: assert property (fab_fault |-> $past(fab_access_valid))
    else $error("fault without an access");
  wr_resp_a: assert property (wr_both_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer not two cycles after both taken");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped before taken");
  rd_resp_a: assert property (rd_taken |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late or address still open");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
endmodule : imfs_status_props

bind imfs_status_top imfs_status_props i_props (.core_clk, .rst, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .fab_access_valid, .fab_access, .fab_fault);

`default_nettype wire

// ==== imfs_status_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "imfs_defs.svh"

// Contract
// RULE1: missed flag register, zero after reset
// RULE2: bits 15..8 flags for pins, converter, radio
// RULE3: bits 7..2 flags for security, serial, sleep, baseband, management
// RULE4: narrow apb or misaligned word sets width fault
// RULE5: unprivileged system or protected write sets privilege fault
// RULE6: apb access above last register is unmapped
// RULE7: access past ram or flash end is unmapped
// RULE8: fault while cause bit set sets overlap
// RULE9: unused bits of both registers read zero
// RULE10: new event while pending sets sticky flag

module imfs_status_top import imfs_pkg::*; #(
  parameter logic [31:0] APB_BASE = `IMFS_APB_BASE,
  parameter int APB_BLOCKS = `IMFS_APB_BLOCKS,
  parameter logic [16*12-1:0] APB_LAST_OFF = `IMFS_APB_LAST_OFF,
  parameter logic [31:0] SYS_APB_BASE = `IMFS_SYS_APB_BASE,
  parameter logic [31:0] SYS_APB_SIZE = `IMFS_SYS_APB_SIZE,
  parameter logic [31:0] SYS_AHB_BASE = `IMFS_SYS_AHB_BASE,
  parameter logic [31:0] SYS_AHB_SIZE = `IMFS_SYS_AHB_SIZE,
  parameter logic [31:0] RAM_BASE = `IMFS_RAM_BASE,
  parameter logic [31:0] RAM_SIZE = `IMFS_RAM_SIZE,
  parameter logic [31:0] RAM_WIN = `IMFS_RAM_WIN,
  parameter logic [31:0] PROT_RAM_BASE = `IMFS_PROT_RAM_BASE,
  parameter logic [31:0] PROT_RAM_SIZE = `IMFS_PROT_RAM_SIZE,
  parameter logic [31:0] FLASH_BASE = `IMFS_FLASH_BASE,
  parameter logic [31:0] FLASH_SIZE = `IMFS_FLASH_SIZE,
  parameter logic [31:0] FLASH_WIN = `IMFS_FLASH_WIN
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // axi4-lite write address
  input wire logic [31:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [31:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // interrupt sources, same clock
  input wire logic [15:0] src_irq_event,
  input wire logic [15:0] src_irq_pending,
  // monitored fabric access, same clock
  input wire logic fab_access_valid,
  input wire imfs_access_s fab_access,
  // fault answer and interrupt
  output logic fab_fault,
  output logic irq
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  // merge a written word into a register under byte strobes
  function automatic logic [31:0] strb_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    strb_merge = res;
  endfunction : strb_merge

  // one-hot register decode, shared by read and write paths
  function automatic logic [3:0] reg_hit(input logic [31:0] a);
    reg_hit = {a == `IMFS_EVENT_MASK_ADDR, a == `IMFS_EVENT_STATUS_ADDR,
               a == `IMFS_AUX_BUS_FAULT_CAUSE_ADDR, a == `IMFS_MISSED_IRQ_FLAGS_ADDR};
  endfunction : reg_hit

  // ****************************************************************
  // state
  // ****************************************************************
  logic aw_full_q, aw_full_d;
  logic w_full_q, w_full_d;
  logic [31:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic awready_q, wready_q, bvalid_q, bvalid_d;
  logic [1:0] bresp_q;
  logic arready_q, rvalid_q, rvalid_d;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [31:0] missed_irq_flags_q, missed_irq_flags_d;
  logic [31:0] aux_bus_fault_cause_q, aux_bus_fault_cause_d;
  logic [31:0] event_status_q, event_status_d;
  logic [31:0] event_mask_q, event_mask_d;
  logic fab_fault_q, irq_q;

  // ****************************************************************
  // write channel handshakes
  // ****************************************************************
  // address and data are caught independently, so either may come first
  wire logic aw_take = s_axi_awvalid && awready_q;
  wire logic w_take = s_axi_wvalid && wready_q;
  wire logic wr_fire = aw_full_q && w_full_q;
  wire logic [3:0] wr_hit = reg_hit(awaddr_q);
  wire logic wr_mapped = |wr_hit;

  assign aw_full_d = !wr_fire && (aw_full_q || aw_take);
  assign w_full_d = !wr_fire && (w_full_q || w_take);
  assign bvalid_d = wr_fire || (bvalid_q && !s_axi_bready);

  // holding registers for the write pair
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= 32'h0000_0000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      if (aw_take) begin
        awaddr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
    end
  end

  // readies drop while a channel is held or a response waits
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= `IMFS_RESP_OKAY;
    end else begin
      awready_q <= !aw_full_d && !bvalid_d;
      wready_q <= !w_full_d && !bvalid_d;
      bvalid_q <= bvalid_d;
      if (wr_fire) begin
        bresp_q <= wr_mapped ? `IMFS_RESP_OKAY : `IMFS_RESP_SLVERR; // unmapped gets slverr
      end
    end
  end

  // ****************************************************************
  // read channel
  // ****************************************************************
  wire logic ar_take = s_axi_arvalid && arready_q;
  wire logic [3:0] rd_hit = reg_hit(s_axi_araddr);

  // unimplemented bits are masked on the way out too
  wire logic [31:0] rd_word =
    ({32{rd_hit[0]}} & missed_irq_flags_q & `IMFS_MISSED_IRQ_FLAGS_MASK) | // [RULE9]
    ({32{rd_hit[1]}} & aux_bus_fault_cause_q & `IMFS_AUX_BUS_FAULT_CAUSE_MASK) | // [RULE9]
    ({32{rd_hit[2]}} & event_status_q) |
    ({32{rd_hit[3]}} & event_mask_q);

  assign rvalid_d = ar_take || (rvalid_q && !s_axi_rready);

  // data is captured at the address edge and held until taken
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `IMFS_RESP_OKAY;
    end else begin
      arready_q <= !rvalid_d;
      rvalid_q <= rvalid_d;
      if (ar_take) begin
        rdata_q <= rd_word;
        rresp_q <= (|rd_hit) ? `IMFS_RESP_OKAY : `IMFS_RESP_SLVERR;
      end
    end
  end

  // ****************************************************************
  // missed interrupt flags
  // ****************************************************************
  // a fresh event on a source still pending means one was lost
  wire logic [31:0] miss_set = {16'h0000, src_irq_event & src_irq_pending} &
                               `IMFS_MISSED_IRQ_FLAGS_MASK; // [RULE10] [RULE2] [RULE3]
  wire logic miss_wr = wr_fire && wr_hit[0];
  wire logic [31:0] miss_base = miss_wr ?
                                strb_merge(missed_irq_flags_q, wdata_q, wstrb_q) :
                                missed_irq_flags_q;

  // hardware set wins over a software write in the same cycle
  assign missed_irq_flags_d = (miss_base | miss_set) &
                              `IMFS_MISSED_IRQ_FLAGS_MASK; // [RULE10] [RULE9]

  // ****************************************************************
  // bus fault causes
  // ****************************************************************
  imfs_cause_s cause;

  imfs_fault_classify #(
    .APB_BASE(APB_BASE),
    .APB_BLOCKS(APB_BLOCKS),
    .APB_LAST_OFF(APB_LAST_OFF),
    .SYS_APB_BASE(SYS_APB_BASE),
    .SYS_APB_SIZE(SYS_APB_SIZE),
    .SYS_AHB_BASE(SYS_AHB_BASE),
    .SYS_AHB_SIZE(SYS_AHB_SIZE),
    .RAM_BASE(RAM_BASE),
    .RAM_SIZE(RAM_SIZE),
    .RAM_WIN(RAM_WIN),
    .PROT_RAM_BASE(PROT_RAM_BASE),
    .PROT_RAM_SIZE(PROT_RAM_SIZE),
    .FLASH_BASE(FLASH_BASE),
    .FLASH_SIZE(FLASH_SIZE),
    .FLASH_WIN(FLASH_WIN)
  ) u_classify (
    .acc(fab_access),
    .cause(cause)
  );

  wire logic fault_now = fab_access_valid && (|cause); // [RULE4] [RULE5] [RULE6] [RULE7]
  // overlap looks at the register as it stood before this fault
  wire logic overlap = fault_now && (|aux_bus_fault_cause_q); // [RULE8]
  wire logic [31:0] fault_set = fault_now ?
    {28'h0000000, cause.bad_width_fault, cause.privilege_fault,
     cause.unmapped_address_fault, overlap} : 32'h0000_0000;
  wire logic aux_wr = wr_fire && wr_hit[1];
  wire logic [31:0] aux_base = aux_wr ?
                               strb_merge(aux_bus_fault_cause_q, wdata_q, wstrb_q) :
                               aux_bus_fault_cause_q;

  // new causes win over a clearing write
  assign aux_bus_fault_cause_d = (aux_base | fault_set) &
                                 `IMFS_AUX_BUS_FAULT_CAUSE_MASK; // [RULE8] [RULE9]

  // ****************************************************************
  // event status and mask
  // ****************************************************************
  wire logic [31:0] ev_set = {30'h00000000, fault_now, |miss_set};
  wire logic st_wr = wr_fire && wr_hit[2];
  wire logic mk_wr = wr_fire && wr_hit[3];
  wire logic [31:0] st_clr = st_wr ? strb_merge(32'h0000_0000, wdata_q, wstrb_q) :
                             32'h0000_0000;

  // write one clears, set in the same cycle wins
  assign event_status_d = ((event_status_q & ~st_clr) | ev_set) & `IMFS_EVENT_MASK_BITS;
  assign event_mask_d = (mk_wr ? strb_merge(event_mask_q, wdata_q, wstrb_q) : event_mask_q) &
                        `IMFS_EVENT_MASK_BITS;

  // ****************************************************************
  // register file
  // ****************************************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      missed_irq_flags_q <= `IMFS_MISSED_IRQ_FLAGS_RESET; // [RULE1]
      aux_bus_fault_cause_q <= `IMFS_AUX_BUS_FAULT_CAUSE_RESET;
      event_status_q <= `IMFS_EVENT_RESET;
      event_mask_q <= `IMFS_EVENT_RESET;
    end else begin
      missed_irq_flags_q <= missed_irq_flags_d;
      aux_bus_fault_cause_q <= aux_bus_fault_cause_d;
      event_status_q <= event_status_d;
      event_mask_q <= event_mask_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // irq follows the stored status one cycle later, so it lags a new event by two cycles
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fab_fault_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      fab_fault_q <= fault_now;
      irq_q <= |(event_status_q & event_mask_q);
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign fab_fault = fab_fault_q;
  assign irq = irq_q;

endmodule : imfs_status_top

`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "imfs_defs.svh"

module tb_top import imfs_pkg::*; ;
  // **********
  // register map and bench state
  // **********
  localparam logic [31:0] MISS = `IMFS_MISSED_IRQ_FLAGS_ADDR;
  localparam logic [31:0] AUX = `IMFS_AUX_BUS_FAULT_CAUSE_ADDR;
  localparam logic [31:0] STAT = `IMFS_EVENT_STATUS_ADDR;
  localparam logic [31:0] MASK = `IMFS_EVENT_MASK_ADDR;
  int failures = 0;
  int checked = 0;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, fab_access_valid = 1'b0;
  logic [15:0] src_irq_event = 16'h0, src_irq_pending = 16'h0;
  imfs_access_s fab_access = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic fab_fault, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;

  // 20 mhz
  always #25 core_clk = ~core_clk;

  // prot inputs are ignored by the design, strobes stay full word
  imfs_status_top i_dut (.core_clk, .rst, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .src_irq_event, .src_irq_pending, .fab_access_valid, .fab_access, .fab_fault, .irq);

  // **********
  // shared tasks
  // **********
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // ready raised late on purpose so the answer has to stand a cycle
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) break;
      if (s_axi_bvalid) s_axi_bready <= 1'b1;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n == 40) begin
      failures++;
      print_verdict();
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) break;
      if (s_axi_rvalid) s_axi_rready <= 1'b1;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n == 40) begin
      failures++;
      print_verdict();
    end
  endtask : axi_rd

  // one access on the fabric, fault sampled once the next edge has landed
  task automatic fab(input imfs_access_s a, output logic f);
    @(posedge core_clk);
    fab_access_valid <= 1'b1;
    fab_access <= a;
    @(posedge core_clk);
    fab_access_valid <= 1'b0;
    #1 f = fab_fault;
  endtask : fab

  task automatic ev(input logic [15:0] e, input logic [15:0] p);
    @(posedge core_clk);
    src_irq_event <= e;
    src_irq_pending <= p;
    @(posedge core_clk);
    src_irq_event <= 16'h0;
    src_irq_pending <= 16'h0;
  endtask : ev

  // **********
  // scenarios
  // **********
  task automatic test_reset;
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(MISS, d, r);
    chk("missed flags after reset", 32'h0, d);
    axi_rd(AUX, d, r);
    chk("fault cause after reset", 32'h0, d);
    axi_rd(MISS + 32'h4, d, r);
    chk("unmapped read resp", 32'h2, {30'h0, r});
    axi_wr(MISS + 32'h4, 32'hffff_ffff, r);
    chk("unmapped write resp", 32'h2, {30'h0, r});
    $display("test reset done");
  endtask : test_reset

  task automatic test_missed;
    logic [31:0] d;
    logic [31:0] exp;
    logic [1:0] r;
    ev(16'hffff, 16'h0000);
    axi_rd(MISS, d, r);
    chk("flags without pending", 32'h0, d);
    exp = 32'h0;
    for (int n = 0; n < 16; n++) begin
      ev(16'h1 << n, 16'hffff);
      if (n >= 2) exp[n] = 1'b1;
      axi_rd(MISS, d, r);
      chk("missed flag", exp, d);
    end
    chk("irq while masked", 32'h0, {31'h0, irq});
    axi_wr(MASK, 32'h1, r);
    axi_rd(STAT, d, r);
    chk("event status", 32'h1, d);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    axi_wr(STAT, 32'h1, r);
    axi_rd(MISS, d, r);
    chk("irq after clear", 32'h0, {31'h0, irq});
    chk("flags stay set", 32'h0000_fffc, d);
    axi_wr(MISS, 32'hffff_ffff, r);
    axi_wr(MISS, 32'h0000_0000, r);
    axi_rd(MISS, d, r);
    chk("flags written zero", 32'h0, d);
    axi_wr(MISS, 32'hffff_ffff, r);
    axi_rd(MISS, d, r);
    chk("flags written ones", 32'h0000_fffc, d);
    $display("test missed done");
  endtask : test_missed

  task automatic test_faults;
    imfs_access_s a [7] = '{'{32'h4000_0004, IMFS_SZ_BYTE, 1'b0, 1'b1},
      '{32'h2000_0002, IMFS_SZ_WORD, 1'b0, 1'b1}, '{32'h4000_0000, IMFS_SZ_WORD, 1'b1, 1'b0},
      '{32'h4000_0100, IMFS_SZ_WORD, 1'b0, 1'b1}, '{32'h2000_3000, IMFS_SZ_WORD, 1'b0, 1'b1},
      '{32'h0002_0000, IMFS_SZ_WORD, 1'b0, 1'b1}, '{32'h4000_0000, IMFS_SZ_WORD, 1'b1, 1'b1}};
    logic [31:0] e [7] = '{32'h8, 32'h8, 32'h4, 32'h2, 32'h2, 32'h2, 32'h0};
    logic [31:0] d;
    logic [1:0] r;
    logic f;
    axi_wr(MASK, 32'h2, r);
    for (int i = 0; i < 7; i++) begin
      axi_wr(AUX, 32'h0, r);
      fab(a[i], f);
      chk("fault pulse", {31'h0, e[i] != 32'h0}, {31'h0, f});
      axi_rd(AUX, d, r);
      chk("fault cause", e[i], d);
    end
    axi_rd(STAT, d, r);
    chk("fault event status", 32'h2, d);
    chk("fault irq", 32'h1, {31'h0, irq});
    axi_wr(STAT, 32'h2, r);
    axi_wr(AUX, 32'h0, r);
    chk("irq after clear", 32'h0, {31'h0, irq});
    fab('{32'h4000_0008, IMFS_SZ_HALF, 1'b0, 1'b1}, f);
    fab(a[3], f);
    axi_rd(AUX, d, r);
    chk("overlap cause", 32'hb, d);
    axi_wr(AUX, 32'hffff_ffff, r);
    axi_rd(AUX, d, r);
    chk("cause written ones", 32'hf, d);
    $display("test faults done");
  endtask : test_faults

  // **********
  // main sequence
  // **********
  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    test_reset();
    test_missed();
    test_faults();
    print_verdict();
  end
endmodule : tb_top

`default_nettype wire
